/* File: verilog/atp_pkg.sv */
/*
 * atp_pkg: constants and carrier types for the converter trigger-program table.
 * assumes: single 100 MHz clock domain, plain register port with 8-bit byte address.
 */
`default_nettype none
package atp_pkg;
  localparam int unsigned NUM_PROG  = 6;             // programs per converter unit
  localparam int unsigned NUM_SLOT  = 4;             // slots per program
  localparam int unsigned SLOT_W    = 8;             // bits per slot within a word
  localparam int unsigned DATA_W    = 12;            // conversion result width
  // register map (byte addresses)
  localparam logic [7:0]  OFS_PROG_BASE  = 8'h00;    // trigger_program_0..5, step 4
  localparam logic [7:0]  OFS_START_BASE = 8'h20;    // program_start_select 0..5, step 4
  localparam logic [7:0]  OFS_STATUS     = 8'h40;    // sequencer status
  localparam logic [7:0]  OFS_RES_BASE   = 8'h60;    // conversion_result_slot 0..3, step 4
  localparam logic [31:0] RST_PROG       = 32'h0000_0000;
  localparam logic [1:0]  RST_START      = 2'h0;
  // slot field positions inside one slot byte
  localparam int unsigned POS_EN    = 7;
  localparam int unsigned POS_PH_HI = 6;
  localparam int unsigned POS_PH_LO = 5;
  localparam int unsigned POS_CH_HI = 4;
  localparam int unsigned POS_CH_LO = 0;
  // phase tag coding
  localparam logic [1:0]  PH_NONE = 2'h0;
  localparam logic [1:0]  PH_U    = 2'h1;
  localparam logic [1:0]  PH_V    = 2'h2;
  localparam logic [1:0]  PH_W    = 2'h3;
  // start select coding
  localparam logic [1:0]  START_TRIG_A = 2'h1;
  localparam logic [1:0]  START_TRIG_B = 2'h2;
  // channel code limits
  localparam logic [4:0]  CH_LAST_COMMON = 5'h0e;    // last input shared by both units
  localparam logic [4:0]  CH_LAST_UNIT_B = 5'h10;    // last input of unit B

  typedef enum logic [1:0] {
    ATP_IDLE = 2'b00,
    ATP_SCAN = 2'b01,
    ATP_WAIT = 2'b11
  } atp_state_e;

  typedef struct packed {
    logic [4:0] chan;                                 // analog input to convert
    logic [1:0] slot;                                 // result slot it lands in
    logic [1:0] phase;                                // phase tag for vector engine
  } atp_req_s;

  typedef struct packed {
    logic [1:0]        slot;
    logic [1:0]        phase;
    logic [DATA_W-1:0] data;
  } atp_res_s;
endpackage : atp_pkg
`default_nettype wire

/* File: verilog/atp_table.sv */
/*
 * atp_table: trigger-program table and conversion sequencer for one converter unit.
 * assumes: pwm triggers and converter handshake come from logic on i_ref_clk;
 *          the converter holds i_conv_done for one cycle per conversion.
 */
// Decided for this implementation: the address map and strobed register access.
// Behaviour
// R1: each unit holds six program registers of four slots, each slot an enable, phase and channel.
// R2: slot m feeds result slot m and is converted only when its enable bit is 1, else skipped.
// R3: the two-bit phase tag travels with the conversion: 00 none, 01 U, 10 V, 11 W.
// R4: channel codes 0 to 14 pick inputs 0 to 14 of the unit in order.
// R5: codes 15 and 16 are inputs only on unit B; all other higher codes are reserved.
// R6: slot m sits in byte m, enable at the top bit, phase below it, channel in the low five.
// R7: each program has a two-bit start select: 01 trigger A, 10 trigger B, 00 or 11 none.
// R8: a started program converts its enabled slots in ascending order, each result tagged.
`timescale 1ns/1ns
`default_nettype none
module atp_table
  import atp_pkg::*;
#(
  parameter bit UNIT_B = 1'b0                        // 1 for unit B input map
) (
  input  wire logic                  i_ref_clk,     // 100 MHz clock
  input  wire logic                  i_rst_b,       // async reset, active low
  input  wire logic                  i_ce,          // clock enable, freezes state when low
  input  wire logic [7:0]            i_addr,        // register byte address
  input  wire logic [31:0]           i_wdata,       // register write data
  input  wire logic                  i_wr,          // write strobe
  input  wire logic                  i_rd,          // read strobe
  output logic [31:0]                o_rdata,       // read data, cycle after i_rd
  input  wire logic                  i_pwm_trigger_a, // pwm trigger a pulse
  input  wire logic                  i_pwm_trigger_b, // pwm trigger b pulse
  output logic                       o_conv_req,    // conversion request level
  output atp_pkg::atp_req_s          o_conv,        // channel, slot and phase of request
  input  wire logic                  i_conv_done,   // conversion finished pulse
  input  wire logic [atp_pkg::DATA_W-1:0] i_conv_data, // conversion result
  output logic                       o_res_valid,   // result written pulse
  output atp_pkg::atp_res_s          o_res          // tagged result
);
  import atp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers and decode
  logic [31:0]       prog_r [NUM_PROG];
  logic [1:0]        start_r [NUM_PROG];
  logic [DATA_W-1:0] res_r [NUM_SLOT];
  logic [NUM_PROG-1:0] pending_r;
  logic [NUM_PROG-1:0] launch;
  atp_state_e        state_r;
  logic [2:0]        prog_sel_r;
  logic [1:0]        slot_r;
  logic [7:0]        slot_byte;
  logic              slot_legal;
  logic              slot_go;
  logic [2:0]        first_pend;

  // per-program register storage and trigger matching
  for (genvar n = 0; n < NUM_PROG; n++) begin : g_prog
    localparam logic [7:0] A_PROG  = OFS_PROG_BASE + 8'(4 * n);
    localparam logic [7:0] A_START = OFS_START_BASE + 8'(4 * n);
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        prog_r[n]  <= RST_PROG;                       // [R1]
        start_r[n] <= RST_START;
      end else if (i_ce && i_wr) begin
        if (i_addr == A_PROG) begin
          prog_r[n] <= i_wdata;                       // [R6]
        end
        if (i_addr == A_START) begin
          start_r[n] <= i_wdata[1:0];
        end
      end
    end
    // 00 and 11 never launch
    assign launch[n] = (start_r[n] == START_TRIG_A && i_pwm_trigger_a) ||
                       (start_r[n] == START_TRIG_B && i_pwm_trigger_b); // [R7]
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read, one cycle latency, unmapped reads zero
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_rdata <= 32'h0000_0000;
      if (i_rd) begin
        for (int n = 0; n < NUM_PROG; n++) begin
          if (i_addr == OFS_PROG_BASE + 8'(4 * n)) begin
            o_rdata <= prog_r[n];
          end
          if (i_addr == OFS_START_BASE + 8'(4 * n)) begin
            o_rdata <= {30'h0000_0000, start_r[n]};
          end
        end
        for (int m = 0; m < NUM_SLOT; m++) begin
          if (i_addr == OFS_RES_BASE + 8'(4 * m)) begin
            o_rdata <= {{(32 - DATA_W){1'b0}}, res_r[m]};
          end
        end
        if (i_addr == OFS_STATUS) begin
          o_rdata <= {18'h0_0000, pending_r, 1'b0, prog_sel_r, slot_r, state_r};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current slot fields and legality of its channel code
  always_comb begin
    slot_byte  = prog_r[prog_sel_r][slot_r*SLOT_W +: SLOT_W];           // [R6]
    slot_legal = (slot_byte[POS_CH_HI:POS_CH_LO] <= CH_LAST_COMMON) ||  // [R4]
                 (UNIT_B && slot_byte[POS_CH_HI:POS_CH_LO] <= CH_LAST_UNIT_B); // [R5]
    slot_go    = slot_byte[POS_EN] && slot_legal;                        // [R2]
    first_pend = 3'h0;
    for (int n = NUM_PROG - 1; n >= 0; n--) begin
      if (pending_r[n]) begin
        first_pend = 3'(n);
      end
    end
  end

  // pending launches, a new trigger wins over the clear of its own bit
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pending_r <= '0;
    end else if (i_ce) begin
      pending_r <= (pending_r &
                    ~((state_r == ATP_IDLE && |pending_r) ? 6'(1) << first_pend : 6'h00))
                   | launch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: lowest pending program first, slots in ascending order
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r    <= ATP_IDLE;
      prog_sel_r <= 3'h0;
      slot_r     <= 2'h0;
      o_conv     <= '0;
    end else if (i_ce) begin
      case (state_r)
        ATP_IDLE: begin
          if (|pending_r) begin
            prog_sel_r <= first_pend;
            slot_r     <= 2'h0;
            state_r    <= ATP_SCAN;
          end
        end
        ATP_SCAN: begin
          if (slot_go) begin
            o_conv.chan  <= slot_byte[POS_CH_HI:POS_CH_LO];            // [R4]
            o_conv.slot  <= slot_r;                                     // [R2]
            o_conv.phase <= slot_byte[POS_PH_HI:POS_PH_LO];            // [R3]
            state_r      <= ATP_WAIT;
          end else if (slot_r == 2'h3) begin
            state_r <= ATP_IDLE;                                        // [R8]
          end else begin
            slot_r <= slot_r + 2'h1;                                    // [R8]
          end
        end
        ATP_WAIT: begin
          if (i_conv_done) begin
            if (slot_r == 2'h3) begin
              state_r <= ATP_IDLE;
            end else begin
              slot_r  <= slot_r + 2'h1;                                 // [R8]
              state_r <= ATP_SCAN;
            end
          end
        end
        default: state_r <= ATP_IDLE;
      endcase
    end
  end

  assign o_conv_req = (state_r == ATP_WAIT);

  // result store and tagged result output
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_res_valid <= 1'b0;
      o_res       <= '0;
      for (int m = 0; m < NUM_SLOT; m++) begin
        res_r[m] <= '0;
      end
    end else if (i_ce) begin
      o_res_valid <= 1'b0;
      if (state_r == ATP_WAIT && i_conv_done) begin
        res_r[o_conv.slot] <= i_conv_data;                              // [R2]
        o_res_valid        <= 1'b1;
        o_res.slot         <= o_conv.slot;                              // [R8]
        o_res.phase        <= o_conv.phase;                             // [R3]
        o_res.data         <= i_conv_data;
      end
    end
  end
endmodule : atp_table
`default_nettype wire

/* File: tb/atp_table_monitor.sv */
/* atp_table_monitor: port checks on the trigger-program table.
   assumes: bound to atp_table, one clock, reset async active low. */
`timescale 1ns/1ns
`default_nettype none
module atp_table_monitor import atp_pkg::*; #(parameter bit UNIT_B = 1'b0) (
  input wire logic              i_ref_clk,   // clock
  input wire logic              i_rst_b,     // reset
  input wire logic              i_ce,        // clock enable
  input wire logic [7:0]        i_addr,      // address
  input wire logic              i_rd,        // read strobe
  input wire logic [31:0]       o_rdata,     // read data
  input wire logic              o_conv_req,  // request
  input wire atp_req_s          o_conv,      // request fields
  input wire logic              i_conv_done, // done pulse
  input wire logic [DATA_W-1:0] i_conv_data, // result
  input wire logic              o_res_valid, // result pulse
  input wire atp_res_s          o_res        // tagged result
);
  ////////////////////////////////////////
  // one domain, so clock and reset are shared
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_done;
    o_conv_req && i_conv_done && i_ce;
  endsequence
  AST_RST_IDLE: assert property ($rose(i_rst_b) |-> !o_conv_req ##1 !o_conv_req)
    else $error("request after reset");
  AST_RD_IDLE: assert property ($past(i_ce) && !$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside slot");
  AST_SEL_BITS: assert property ($past(i_ce && i_rd && i_addr[7:5] == 3'h1) |-> o_rdata[31:2] == 30'h0)
    else $error("select upper bits set");
  AST_CH_LEGAL: assert property (o_conv_req |-> o_conv.chan <= (UNIT_B ? CH_LAST_UNIT_B : CH_LAST_COMMON))
    else $error("reserved channel requested");
  AST_REQ_HOLD: assert property (o_conv_req && !i_conv_done |=> o_conv_req && $stable(o_conv))
    else $error("request not held");
  AST_RES_TAG: assert property (s_done |=> o_res_valid && o_res == {$past(o_conv.slot), $past(o_conv.phase), $past(i_conv_data)})
    else $error("result tag wrong");
  AST_REQ_DROP: assert property (s_done |=> !o_conv_req)
    else $error("request kept after done");
  AST_RES_CAUSE: assert property (o_res_valid && $past(i_ce) |-> $past(o_conv_req && i_conv_done))
    else $error("result without conversion");
endmodule : atp_table_monitor
bind atp_table atp_table_monitor #(.UNIT_B(UNIT_B)) u_mon (.i_ref_clk(i_ref_clk),
  .i_rst_b(i_rst_b), .i_ce(i_ce), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_conv_req(o_conv_req), .o_conv(o_conv), .i_conv_done(i_conv_done),
  .i_conv_data(i_conv_data), .o_res_valid(o_res_valid), .o_res(o_res));
`default_nettype wire

/* File: tb/atp_conv_model.sv */
/* atp_conv_model: converter answering requests promptly or slowly.
   assumes: same clock as the table, request held until done. */
`timescale 1ns/1ns
`default_nettype none
module atp_conv_model import atp_pkg::*; (
  input wire logic              i_ref_clk, // clock
  input wire logic              i_rst_b,   // reset
  input wire logic              i_req,     // request level
  input wire atp_req_s          i_conv,    // request fields
  input wire logic              i_slow,    // slow answer
  output logic                  o_done,    // one-cycle done
  output logic [DATA_W-1:0]     o_data     // result
);
  ////////////////////////////////////////
  logic [2:0] cnt_r;
  // count wait cycles, then pulse done once per request
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r  <= 3'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= i_req && !o_done && cnt_r == (i_slow ? 3'h5 : 3'h0);
      cnt_r  <= (i_req && !o_done) ? cnt_r + 3'h1 : 3'h0;
    end
  end
  // result names its request; inverted outside done so stale data shows
  assign o_data = o_done ? {i_conv.chan, i_conv.slot, i_conv.phase, 3'h5} :
                  ~{i_conv.chan, i_conv.slot, i_conv.phase, 3'h5};
endmodule : atp_conv_model
`default_nettype wire

/* File: tb/test_adc_trigger_program_table.sv */
/* test_adc_trigger_program_table: register and conversion-run bench.
   assumes: unit A map, clock enable held high. */
`timescale 1ns/1ns
`default_nettype none
module test_adc_trigger_program_table;
  import atp_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, ta = 1'b0, tb = 1'b0, slow = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, w, lfsr = 32'h921150d5;
  logic        conv_req, done, res_valid;
  logic [11:0] cdata;
  atp_req_s    conv;
  atp_res_s    res, got_q[$], exp_q[$];
  int          mismatches = 0, n_tests = 0, k;
  logic [11:0] exp_res [4] = '{default: 12'h000}; // last value expected in each result register
  ////////////////////////////////////////
  always #5 ref_clk = ~ref_clk;
  atp_table #(.UNIT_B(1'b0)) dut (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_ce(1'b1),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_pwm_trigger_a(ta), .i_pwm_trigger_b(tb), .o_conv_req(conv_req), .o_conv(conv),
    .i_conv_done(done), .i_conv_data(cdata), .o_res_valid(res_valid), .o_res(res));
  atp_conv_model u_conv (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_req(conv_req),
    .i_conv(conv), .i_slow(slow), .o_done(done), .o_data(cdata));
  // collect every result pulse
  always @(posedge ref_clk) if (res_valid === 1'b1) got_q.push_back(res);
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  // enabled slots with a unit A channel, ascending
  function automatic void plan(input logic [31:0] v);
    logic [7:0] s;
    for (int m = 0; m < NUM_SLOT; m++) begin
      s = v[m*8 +: 8];
      if (s[POS_EN] && s[4:0] <= CH_LAST_COMMON) begin
        exp_q.push_back({2'(m), s[6:5], s[4:0], 2'(m), s[6:5], 3'h5});
        exp_res[m] = {s[4:0], 2'(m), s[6:5], 3'h5};
      end
    end
  endfunction : plan
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w_n, input logic [7:0] a, input logic [31:0] d, input string s);
    @(posedge ref_clk);
    addr <= a; wdata <= d; wr <= w_n; rd <= !w_n;
    @(posedge ref_clk);
    wr <= 1'b0; rd <= 1'b0;
    #1 if (!w_n) check(rdata, d, s);
  endtask : bus
  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // registers, then triggered runs
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int n = 0; n < NUM_PROG; n++) begin
      bus(0, OFS_PROG_BASE + 8'(4*n), RST_PROG, "prog reset");
      bus(0, OFS_START_BASE + 8'(4*n), 32'h0, "start reset");
      lfsr = nxt(lfsr);
      bus(1, OFS_PROG_BASE + 8'(4*n), lfsr, "");
      bus(1, OFS_START_BASE + 8'(4*n), lfsr, "");
      bus(0, OFS_PROG_BASE + 8'(4*n), lfsr, "prog rw");
      bus(0, OFS_START_BASE + 8'(4*n), {30'h0, lfsr[1:0]}, "start rw");
      bus(1, OFS_START_BASE + 8'(4*n), 32'h0, "");
    end
    bus(1, 8'h80, 32'hffffffff, "");
    bus(0, 8'h80, 32'h0, "unmapped");
    for (int i = 0; i < 16; i++) begin
      lfsr = nxt(lfsr);
      w = (i == 1) ? 32'hd08fee80 : (lfsr | 32'h80000080);
      slow <= lfsr[8];
      bus(1, OFS_PROG_BASE, w, "");
      bus(1, OFS_START_BASE, 32'(i % 4), "");
      if (i % 4 == (i[2] ? 2 : 1)) plan(w);
      @(posedge ref_clk);
      ta <= !i[2];
      tb <= i[2];
      @(posedge ref_clk);
      ta <= 1'b0; tb <= 1'b0;
      for (k = 0; k < 100 && got_q.size() < exp_q.size(); k++) @(posedge ref_clk);
      if (k == 100) begin
        mismatches++;
        end_sim();
      end
      repeat (8) @(posedge ref_clk);
      check(32'(got_q.size()), 32'(exp_q.size()), "result count");
      while (got_q.size() > 0 && exp_q.size() > 0)
        check({16'h0, got_q.pop_front()}, {16'h0, exp_q.pop_front()}, "result");
      got_q = {};
      exp_q = {};
      // stored results read back over the register port
      for (int m = 0; m < NUM_SLOT; m++)
        bus(0, OFS_RES_BASE + 8'(4*m), 32'(exp_res[m]), "result reg");
    end
    end_sim();
  end
endmodule : test_adc_trigger_program_table
`default_nettype wire
